/* core/quad_channel_adc_control.sv */
`timescale 1ns/1ns
module quad_channel_adc_control
  import adc_ctrl_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_start,
  input wire cfg_t i_cfg,
  input wire logic i_alarm_clear,
  input wire logic i_sar_cmp,
  input wire logic i_bus_addr_select_pin,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic [CH_N-1:0] o_mux_output_pin_sel,
  output logic o_mux_to_analog_ground,
  output logic o_sample_switch,
  output logic [RES_W-1:0] o_dac_code,
  output logic o_ext_power_ctrl_out,
  output logic o_int_n,
  output logic o_busy,
  output logic [CH_N-1:0] o_alarm_flags,
  output result_bank_t o_results,
  output logic o_sda_out,
  output logic o_sda_oe
);

  // ***********************************************************
  // state
  // ***********************************************************
  typedef struct packed {
    conv_state_t st;
    logic cmp_s1;
    logic cmp_s2;
    logic addr_s1;
    logic addr_s2;
    logic scl_s1;
    logic scl_s2;
    logic sda_s1;
    logic sda_s2;
    logic [TMR_W-1:0] timer;
    logic [TMR_W-1:0] acq_len;
    logic [1:0] ch;
    logic scan;
    logic [RES_W-1:0] code;
    logic [RES_W-1:0] trial;
    logic [RES_W-1:0] mask;
    logic [BITT_W-1:0] bit_tmr;
    result_bank_t results;
    logic [CH_N-1:0] alarm;
    logic [CH_N-1:0] mux_sel;
    logic mux_gnd;
    logic sample_sw;
    logic pwr;
    logic busy;
    logic int_n;
  } ctl_t;

  ctl_t s;
  ctl_t next_s;

  // acquisition length in clock cycles for a given setting
  function automatic logic [TMR_W-1:0] acq_cycles(input logic [ACQ_SET_W-1:0] setting);
    acq_cycles = TMR_W'(ACQ_MIN_CYCLES) + TMR_W'(setting) * TMR_W'(ACQ_STEP_CYCLES);
  endfunction

  function automatic logic [CH_N-1:0] chan_onehot(input logic [1:0] ch);
    chan_onehot = CH_N'(1) << ch;
  endfunction

  // ***********************************************************
  // sequencer and successive approximation
  // ***********************************************************
  always_comb begin
    next_s = s;
    // pin inputs pass two flip-flops before any use
    next_s.cmp_s1 = i_sar_cmp;
    next_s.cmp_s2 = s.cmp_s1;
    next_s.addr_s1 = i_bus_addr_select_pin;
    next_s.addr_s2 = s.addr_s1;
    next_s.scl_s1 = i_scl;
    next_s.scl_s2 = s.scl_s1;
    next_s.sda_s1 = i_sda;
    next_s.sda_s2 = s.sda_s1;
    // clear first so a trip in the same cycle still sets the flag
    next_s.alarm = s.alarm & ~{CH_N{i_alarm_clear}};
    case (s.st)
      ST_IDLE: begin
        if (i_start) begin
          next_s.ch = i_cfg.scan ? 2'h0 : i_cfg.channel;
          next_s.scan = i_cfg.scan;
          next_s.st = ST_ACQ;
          next_s.timer = '0;
          next_s.acq_len = acq_cycles(i_cfg.acquisition_time_setting);
        end
      end
      ST_ACQ: begin
        // all intervals counted on the local clock
        if (s.timer == s.acq_len - TMR_W'(1)) begin
          next_s.st = ST_CONV;
          next_s.timer = '0;
          next_s.code = CODE_ZERO;
          next_s.trial = CODE_MSB;
          next_s.mask = CODE_MSB;
          next_s.bit_tmr = '0;
        end else begin
          next_s.timer = s.timer + TMR_W'(1);
        end
      end
      ST_CONV: begin
        next_s.timer = s.timer + TMR_W'(1);
        if (s.mask != CODE_ZERO) begin
          if (s.bit_tmr == BITT_W'(BIT_CYCLES - 1)) begin
            // trial bit is kept while the held input is above the dac level;
            // the search spans only 000h..FFFh, so out-of-range inputs pin
            // the code at an end and can never wrap
            next_s.code = s.cmp_s2 ? s.trial : s.code;
            next_s.mask = s.mask >> 1;
            next_s.trial = (s.cmp_s2 ? s.trial : s.code) | (s.mask >> 1);
            next_s.bit_tmr = '0;
          end else begin
            next_s.bit_tmr = s.bit_tmr + BITT_W'(1);
          end
        end
        // fixed conversion time keeps the channel rate bounded
        if (s.timer == TMR_W'(CONV_CYCLES - 1)) begin
          // only the converted channel is written, all at once
          next_s.results[s.ch] = s.code;
          // window trips on the upper 8 result bits
          if (i_cfg.compare_en &&
              (s.code[RES_W-1 -: LIMIT_W] <= i_cfg.lower_limit_value ||
               s.code[RES_W-1 -: LIMIT_W] >= i_cfg.upper_limit_value)) begin
            next_s.alarm = next_s.alarm | chan_onehot(s.ch);
          end
          if (s.scan && s.ch != LAST_CH) begin
            next_s.ch = s.ch + 2'h1;
            next_s.st = ST_ACQ;
            next_s.timer = '0;
            next_s.acq_len = acq_cycles(i_cfg.acquisition_time_setting);
          end else begin
            next_s.st = ST_IDLE;
          end
        end
      end
      default: begin
        next_s.st = ST_IDLE;
      end
    endcase
    // one input on the mux, or ground for a zero-volt
    next_s.mux_gnd = i_cfg.ground_test;
    next_s.mux_sel = (next_s.st != ST_IDLE && !i_cfg.ground_test) ?
                     chan_onehot(next_s.ch) : '0;
    // capacitor tracks in acquisition and is held in conversion
    next_s.sample_sw = (next_s.st == ST_ACQ);
    // conditioning powered only around a measurement unless held on
    next_s.pwr = (next_s.st != ST_IDLE) | i_cfg.power_hold;
    next_s.busy = (next_s.st != ST_IDLE);
    next_s.int_n = ~(|next_s.alarm);
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      s <= '0;
      s.int_n <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // ***********************************************************
  // serial target port
  // ***********************************************************
  result_bus_target u_target (
    .i_mclk(i_mclk),
    .i_srst(i_srst),
    .i_scl(s.scl_s2),
    .i_sda(s.sda_s2),
    .i_addr_sel(s.addr_s2),
    .i_results(s.results),
    .o_sda_out(o_sda_out),
    .o_sda_oe(o_sda_oe)
  );

  // outputs straight from the state flops
  assign o_mux_output_pin_sel = s.mux_sel;
  assign o_mux_to_analog_ground = s.mux_gnd;
  assign o_sample_switch = s.sample_sw;
  assign o_dac_code = s.trial;
  assign o_ext_power_ctrl_out = s.pwr;
  assign o_int_n = s.int_n;
  assign o_busy = s.busy;
  assign o_alarm_flags = s.alarm;
  assign o_results = s.results;

endmodule

/* core/adc_ctrl_pkg.sv */
// Behaviour
// - each conversion of the selected channel finishes with no pipeline delay and lands in that channel's own result register.
// - for every conversion outside the ground test exactly one of the four inputs is routed to the multiplexer output.
// - the multiplexer output can instead be tied to analog ground to convert a zero-volt test level.
// - the sampling switch stays closed, tracking the converter input, for the whole acquisition interval.
// - the sampling switch opens for the conversion interval and the held voltage is resolved.
// - every interval is counted from the local clock, and the host supplies no clock.
// - results are unsigned 12-bit codes, zero input giving 000h and full scale giving FFFh.
// - inputs below zero or above full scale give the end codes and never wrap.
// - one channel takes at least the 6 us least acquisition plus the 4 us conversion.
// - an enableable window comparator with upper and lower limits checks each result.
// - the active-low interrupt pin asserts while the monitor holds an alarm.
// - the target answers one of two bus addresses picked by the address-select pin, and the host uses that one.
// - the serial target port works at standard and fast mode rates up to 0.4 MHz clock.
// - a power-control output switches external conditioning off between measurements.
// - acquisition lasts 6 us plus the acquisition-time setting times 2 us.
// - the comparator trips when the result is at or below the lower limit or at or above the upper limit.
package adc_ctrl_pkg;

  // ***********************************************************
  // timing
  // ***********************************************************
  localparam int CLK_MHZ = 100;
  localparam int ACQ_MIN_NS = 6000;
  localparam int ACQ_STEP_NS = 2000;
  localparam int CONV_NS = 4000;
  localparam int ACQ_MIN_CYCLES = (ACQ_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int ACQ_STEP_CYCLES = (ACQ_STEP_NS * CLK_MHZ + 999) / 1000;
  localparam int CONV_CYCLES = CONV_NS * CLK_MHZ / 1000;

  // ***********************************************************
  // widths and codes
  // ***********************************************************
  localparam int RES_W = 12;
  localparam int CH_N = 4;
  localparam int LIMIT_W = 8;
  localparam int TMR_W = 13;
  localparam int ACQ_SET_W = 5;
  localparam int BITT_W = 6;
  localparam int BIT_CYCLES = CONV_CYCLES / RES_W;
  localparam logic [RES_W-1:0] CODE_ZERO = 12'h000;
  localparam logic [RES_W-1:0] CODE_MSB = 12'h800;
  localparam logic [1:0] LAST_CH = 2'h3;
  // base target address; the select pin supplies bit 0 (plain default)
  localparam logic [6:0] BUS_ADDR_BASE = 7'h48;

  typedef logic [RES_W-1:0] result_t;
  typedef result_t [CH_N-1:0] result_bank_t;

  // configuration from the surrounding logic
  typedef struct packed {
    logic [1:0] channel;
    logic scan;
    logic ground_test;
    logic [ACQ_SET_W-1:0] acquisition_time_setting;
    logic compare_en;
    logic [LIMIT_W-1:0] upper_limit_value;
    logic [LIMIT_W-1:0] lower_limit_value;
    logic power_hold;
  } cfg_t;

  typedef enum logic [1:0] {ST_IDLE, ST_ACQ, ST_CONV} conv_state_t;

  typedef enum logic [3:0] {
    BS_IDLE, BS_ADDR, BS_ADDR_DONE, BS_ACK_ADDR, BS_WRITE, BS_WR_DONE,
    BS_ACK_WR, BS_READ, BS_RD_ACK, BS_RD_NEXT
  } bus_state_t;

endpackage

/* core/result_bus_target.sv */
`timescale 1ns/1ns
module result_bus_target
  import adc_ctrl_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic i_addr_sel,
  input wire result_bank_t i_results,
  output logic o_sda_out,
  output logic o_sda_oe
);

  // ***********************************************************
  // state
  // ***********************************************************
  typedef struct packed {
    bus_state_t st;
    logic scl_d;
    logic sda_d;
    logic [2:0] cnt;
    logic [7:0] shreg;
    logic rw;
    logic first_wr;
    logic [2:0] ptr;
    logic oe;
  } tgt_t;

  tgt_t s;
  tgt_t next_s;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic [7:0] rd_byte;

  // pointer bits [2:1] pick the channel, bit 0 picks high or low byte
  function automatic logic [7:0] pick_byte(input result_bank_t res, input logic [2:0] ptr);
    result_t r;
    r = res[ptr[2:1]];
    pick_byte = ptr[0] ? {r[3:0], 4'h0} : r[11:4];
  endfunction

  // edges of the already synchronised bus lines
  assign scl_rise = i_scl & ~s.scl_d;
  assign scl_fall = ~i_scl & s.scl_d;
  assign start_seen = i_scl & s.scl_d & s.sda_d & ~i_sda;
  assign stop_seen = i_scl & s.scl_d & ~s.sda_d & i_sda;
  assign rd_byte = pick_byte(i_results, s.ptr);

  // ***********************************************************
  // byte engine, sampling on rising and driving on falling clock
  // ***********************************************************
  always_comb begin
    next_s = s;
    next_s.scl_d = i_scl;
    next_s.sda_d = i_sda;
    if (start_seen) begin
      next_s.st = BS_ADDR;
      next_s.cnt = 3'h0;
      next_s.oe = 1'b0;
    end else if (stop_seen) begin
      next_s.st = BS_IDLE;
      next_s.oe = 1'b0;
    end else begin
      case (s.st)
        BS_ADDR, BS_WRITE: begin
          if (scl_rise) begin
            next_s.shreg = {s.shreg[6:0], i_sda};
            next_s.cnt = s.cnt + 3'h1;
            if (s.cnt == 3'h7) begin
              next_s.st = (s.st == BS_ADDR) ? BS_ADDR_DONE : BS_WR_DONE;
            end
          end
        end
        BS_ADDR_DONE: begin
          if (scl_fall) begin
            // only the address the pin selects is acknowledged
            if (s.shreg[7:1] == {BUS_ADDR_BASE[6:1], i_addr_sel}) begin
              next_s.oe = 1'b1;
              next_s.rw = s.shreg[0];
              next_s.st = BS_ACK_ADDR;
            end else begin
              next_s.st = BS_IDLE;
            end
          end
        end
        BS_ACK_ADDR: begin
          if (scl_fall) begin
            next_s.cnt = 3'h0;
            if (s.rw) begin
              next_s.shreg = rd_byte;
              next_s.oe = ~rd_byte[7];
              next_s.st = BS_READ;
            end else begin
              next_s.oe = 1'b0;
              next_s.first_wr = 1'b1;
              next_s.st = BS_WRITE;
            end
          end
        end
        BS_WR_DONE: begin
          if (scl_fall) begin
            // first written byte sets the read pointer
            if (s.first_wr) begin
              next_s.ptr = s.shreg[2:0];
            end
            next_s.first_wr = 1'b0;
            next_s.oe = 1'b1;
            next_s.st = BS_ACK_WR;
          end
        end
        BS_ACK_WR: begin
          if (scl_fall) begin
            next_s.oe = 1'b0;
            next_s.st = BS_WRITE;
          end
        end
        BS_READ: begin
          if (scl_fall) begin
            if (s.cnt == 3'h7) begin
              next_s.oe = 1'b0;
              next_s.ptr = s.ptr + 3'h1;
              next_s.st = BS_RD_ACK;
            end else begin
              next_s.shreg = {s.shreg[6:0], 1'b0};
              next_s.oe = ~s.shreg[6];
              next_s.cnt = s.cnt + 3'h1;
            end
          end
        end
        BS_RD_ACK: begin
          if (scl_rise) begin
            next_s.st = i_sda ? BS_IDLE : BS_RD_NEXT;
          end
        end
        BS_RD_NEXT: begin
          if (scl_fall) begin
            // byte is copied whole, so a completing conversion cannot tear it
            next_s.shreg = rd_byte;
            next_s.oe = ~rd_byte[7];
            next_s.cnt = 3'h0;
            next_s.st = BS_READ;
          end
        end
        default: begin
          next_s.st = BS_IDLE;
        end
      endcase
    end
  end

  // clock is never stretched, so any rate the sampler resolves works
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      s <= '0;
      s.scl_d <= 1'b1;
      s.sda_d <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign o_sda_oe = s.oe;
  assign o_sda_out = s.first_wr & 1'b0;

endmodule

/* verif/quad_channel_adc_control_checker.sv */
`timescale 1ns/1ns
module quad_channel_adc_control_checker
  import adc_ctrl_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_start,
  input wire cfg_t i_cfg,
  input wire logic i_alarm_clear,
  input wire logic [CH_N-1:0] o_mux_output_pin_sel,
  input wire logic o_mux_to_analog_ground,
  input wire logic o_sample_switch,
  input wire logic [RES_W-1:0] o_dac_code,
  input wire logic o_ext_power_ctrl_out,
  input wire logic o_int_n,
  input wire logic o_busy,
  input wire logic [CH_N-1:0] o_alarm_flags,
  input wire result_bank_t o_results
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_srst);
  logic [TMR_W-1:0] acq_len;
  logic [TMR_W-1:0] conv_len;
  // phase lengths measured from the outputs only
  always_ff @(posedge i_mclk) begin
    acq_len <= (o_sample_switch && !i_srst) ? acq_len + 1'b1 : '0;
    conv_len <= (o_busy && !o_sample_switch && !i_srst) ? conv_len + 1'b1 : '0;
  end
  sequence s_take;
    i_start && !o_busy;
  endsequence
  sequence s_track;
    o_busy && o_sample_switch && o_ext_power_ctrl_out;
  endsequence
  a_start_tracks: assert property (s_take |=> s_track)
    else $error("start did not open acquisition");
  a_mux_one_hot: assert property (o_sample_switch && !o_mux_to_analog_ground
    |-> $onehot(o_mux_output_pin_sel))
    else $error("mux select not one-hot");
  a_ground_mux: assert property (o_busy && o_mux_to_analog_ground && $past(o_mux_to_analog_ground)
    |-> o_mux_output_pin_sel == 4'h0)
    else $error("input routed during ground test");
  a_acq_length: assert property ($fell(o_sample_switch) |->
    acq_len == ACQ_MIN_CYCLES + ACQ_STEP_CYCLES * $past(i_cfg.acquisition_time_setting))
    else $error("acquisition length wrong");
  a_conv_first_trial: assert property ($fell(o_sample_switch) && o_busy
    |-> o_dac_code == CODE_MSB && !o_sample_switch)
    else $error("conversion did not start at mid code");
  a_result_hold: assert property (!$stable(o_results)
    |-> conv_len >= 13'h18F && conv_len <= 13'h191)
    else $error("result changed outside conversion end");
  a_int_level: assert property ($stable(|o_alarm_flags) |-> o_int_n == !(|o_alarm_flags))
    else $error("interrupt pin disagrees with alarms");
  a_alarm_clear: assert property (i_alarm_clear |=> o_alarm_flags == 4'h0 || !$stable(o_results))
    else $error("alarm flags not cleared");
  a_power_busy: assert property (o_busy |-> o_ext_power_ctrl_out)
    else $error("power output low while busy");
endmodule

/* verif/analog_front_model.sv */
`timescale 1ns/1ns
module analog_front_model
  import adc_ctrl_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_sample,
  input wire logic [CH_N-1:0] i_sel,
  input wire logic i_gnd,
  input wire logic [RES_W-1:0] i_dac,
  input int i_level [CH_N],
  output logic o_cmp
);
  int held = 0;
  // the cap tracks the routed input only while the switch is closed
  always @(posedge i_mclk) begin
    if (i_sample) begin
      held <= -1;
      for (int k = 0; k < CH_N; k++) if (i_sel[k]) held <= i_level[k];
      if (i_gnd) held <= 0;
    end
  end
  // half-LSB offset so a level equal to the trial code keeps the bit; out-of-range levels
  // pin the search at an end code
  assign o_cmp = (2 * held + 1) > 2 * int'(i_dac);
endmodule

/* verif/quad_channel_adc_control_test.sv */
`timescale 1ns/1ns
module quad_channel_adc_control_test;
  import adc_ctrl_pkg::*;
  logic i_mclk = 1'b0, i_srst = 1'b1, i_start = 1'b0, i_alarm_clear = 1'b0, cmp;
  cfg_t cfg = '0, nc;
  int level [CH_N] = '{0, 0, 0, 0};
  int corner [4] = '{-9, 0, 4095, 5000};
  logic [RES_W-1:0] exp_res [CH_N] = '{12'h000, 12'h000, 12'h000, 12'h000};
  logic [CH_N-1:0] exp_flag = 4'h0, sel, flags;
  logic gnd, samp, pwr, int_n, busy, sda_out, sda_oe;
  logic scl = 1'b1, sda_m = 1'b1, addr_pin = 1'b0;
  logic [15:0] rd_word;
  int rch;
  // open-drain line: the host releases high, the target can only pull it low
  wire sda_line = sda_m & (sda_oe ? sda_out : 1'b1);
  logic [RES_W-1:0] dac;
  result_bank_t res;
  int n_mismatch = 0, checks = 0;
  initial forever #5 i_mclk = ~i_mclk;
  quad_channel_adc_control u_dut (.i_mclk(i_mclk), .i_srst(i_srst), .i_start(i_start),
    .i_cfg(cfg), .i_alarm_clear(i_alarm_clear), .i_sar_cmp(cmp),
    .i_bus_addr_select_pin(addr_pin), .i_scl(scl), .i_sda(sda_line),
    .o_mux_output_pin_sel(sel), .o_mux_to_analog_ground(gnd),
    .o_sample_switch(samp), .o_dac_code(dac), .o_ext_power_ctrl_out(pwr), .o_int_n(int_n),
    .o_busy(busy), .o_alarm_flags(flags), .o_results(res), .o_sda_out(sda_out),
    .o_sda_oe(sda_oe));
  analog_front_model u_afe (.i_mclk(i_mclk), .i_sample(samp), .i_sel(sel), .i_gnd(gnd),
    .i_dac(dac), .i_level(level), .o_cmp(cmp));
  // expected code: unsigned, pinned at both ends
  function automatic logic [RES_W-1:0] clip(int v);
    if (v < 0) return 12'h000;
    if (v > 4095) return 12'hFFF;
    return v[RES_W-1:0];
  endfunction
  function automatic logic trip(logic [RES_W-1:0] r);
    return cfg.compare_en && (r[11:4] <= cfg.lower_limit_value || r[11:4] >= cfg.upper_limit_value);
  endfunction
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // one start, a refused start mid-run, bounded wait, then compare the whole bank
  task automatic convert();
    int n;
    @(posedge i_mclk) i_start <= 1'b1;
    @(posedge i_mclk) i_start <= 1'b0;
    for (n = 0; n < 8000; n++) begin
      @(posedge i_mclk) i_start <= (n == 50);
      #1;
      if (busy === 1'b0) break;
    end
    if (n == 8000) begin
      n_mismatch++;
      close_out();
    end
    for (int c = 0; c < CH_N; c++) begin
      if (cfg.scan || cfg.channel == c) begin
        exp_res[c] = clip(cfg.ground_test ? 0 : level[c]);
        exp_flag[c] = exp_flag[c] | trip(exp_res[c]);
      end
      check("result", 16'(res[c]), 16'(exp_res[c]));
    end
    check("alarm flags", 16'(flags), 16'(exp_flag));
    check("int_n", 16'(int_n), 16'(exp_flag == 4'h0));
  endtask
  task automatic apply();
    @(posedge i_mclk) cfg <= nc;
    @(posedge i_mclk);
  endtask
  // ***********************************************************
  // bus host: a bit takes 4 * QTR + 3 cycles, so scl stays under 0.4 MHz
  // ***********************************************************
  localparam int QTR = 65;
  // data changes in the low phase and is read in the middle of the high phase
  task automatic bus_bit(input logic b, output logic seen);
    @(posedge i_mclk) sda_m <= b;
    repeat (QTR) @(posedge i_mclk);
    @(posedge i_mclk) scl <= 1'b1;
    repeat (QTR) @(posedge i_mclk);
    #1 seen = sda_line;
    repeat (QTR) @(posedge i_mclk);
    @(posedge i_mclk) scl <= 1'b0;
    repeat (QTR) @(posedge i_mclk);
  endtask
  // start or repeated start: sda falls while scl is high
  task automatic bus_start();
    @(posedge i_mclk) sda_m <= 1'b1;
    repeat (QTR) @(posedge i_mclk);
    @(posedge i_mclk) scl <= 1'b1;
    repeat (QTR) @(posedge i_mclk);
    @(posedge i_mclk) sda_m <= 1'b0;
    repeat (QTR) @(posedge i_mclk);
    @(posedge i_mclk) scl <= 1'b0;
  endtask
  task automatic bus_stop();
    @(posedge i_mclk) sda_m <= 1'b0;
    repeat (QTR) @(posedge i_mclk);
    @(posedge i_mclk) scl <= 1'b1;
    repeat (QTR) @(posedge i_mclk);
    @(posedge i_mclk) sda_m <= 1'b1;
    repeat (QTR) @(posedge i_mclk);
  endtask
  // eight bits msb first, then the ninth; a released bit reads back the target
  task automatic bus_byte(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
    output logic ack);
    for (int i = 7; i >= 0; i--) bus_bit(tx[i], rx[i]);
    bus_bit(ack_in, ack);
  endtask
  // pointer write, repeated start, then high and low byte of one channel
  task automatic bus_read(input logic [1:0] ch, input logic pin, output logic [15:0] word);
    logic [7:0] d;
    logic a;
    @(posedge i_mclk) addr_pin <= pin;
    repeat (4) @(posedge i_mclk);
    bus_start();
    bus_byte({BUS_ADDR_BASE[6:1], pin, 1'b0}, 1'b1, d, a);
    check("write address ack", 16'(a), 16'h0000);
    bus_byte({5'h00, ch, 1'b0}, 1'b1, d, a);
    check("pointer ack", 16'(a), 16'h0000);
    bus_start();
    bus_byte({BUS_ADDR_BASE[6:1], pin, 1'b1}, 1'b1, d, a);
    check("read address ack", 16'(a), 16'h0000);
    bus_byte(8'hFF, 1'b0, word[15:8], a);
    bus_byte(8'hFF, 1'b1, word[7:0], a);
    bus_stop();
  endtask
  // the address that the pin does not select must be left unanswered
  task automatic bus_foreign(input logic pin);
    logic [7:0] d;
    logic a;
    bus_start();
    bus_byte({BUS_ADDR_BASE[6:1], ~pin, 1'b1}, 1'b1, d, a);
    check("foreign address nack", 16'(a), 16'h0001);
    bus_stop();
  endtask
  // ***********************************************************
  // main sequence
  // ***********************************************************
  initial begin
    void'($urandom(65774));
    repeat (8) @(posedge i_mclk);
    i_srst <= 1'b0;
    repeat (3) @(posedge i_mclk);
    // single channels; first four runs hit the end codes and beyond
    for (int k = 0; k < 10; k++) begin
      for (int c = 0; c < CH_N; c++) level[c] = (k < 4) ? corner[(c + k) % 4] : $urandom_range(0, 4095);
      nc = '0;
      nc.channel = 2'($urandom_range(0, 3));
      nc.acquisition_time_setting = 5'($urandom_range(0, 1));
      nc.compare_en = (k < 4) | 1'($urandom_range(0, 1));
      nc.upper_limit_value = 8'($urandom_range(0, 255));
      nc.lower_limit_value = 8'($urandom_range(0, 255));
      apply();
      convert();
    end
    $display("single conversions done");
    // scan of all four, then the same scan with the ground tie
    nc.scan = 1'b1;
    nc.acquisition_time_setting = 5'h01;
    apply();
    convert();
    // read a randomly picked channel back over the bus at each pin level, drawing the channel again for each read, so it can repeat
    for (int r = 0; r < 2; r++) begin
      rch = $urandom_range(0, 3);
      bus_read(2'(rch), 1'(r), rd_word);
      check("bus read", rd_word, {exp_res[rch], 4'h0});
    end
    bus_foreign(1'b1);
    $display("bus reads done");
    nc.ground_test = 1'b1;
    apply();
    convert();
    $display("scans done");
    @(posedge i_mclk) i_alarm_clear <= 1'b1;
    @(posedge i_mclk) i_alarm_clear <= 1'b0;
    exp_flag = 4'h0;
    repeat (2) @(posedge i_mclk);
    check("cleared flags", 16'(flags), 16'h0000);
    check("int_n idle", 16'(int_n), 16'h0001);
    nc.power_hold = 1'b1;
    apply();
    repeat (2) @(posedge i_mclk);
    check("power hold", 16'(pwr), 16'h0001);
    nc.power_hold = 1'b0;
    apply();
    repeat (2) @(posedge i_mclk);
    check("power off", 16'(pwr), 16'h0000);
    $display("alarm and power done");
    close_out();
  end
endmodule

bind quad_channel_adc_control quad_channel_adc_control_checker u_chk (.i_mclk(i_mclk),
  .i_srst(i_srst), .i_start(i_start), .i_cfg(i_cfg), .i_alarm_clear(i_alarm_clear),
  .o_mux_output_pin_sel(o_mux_output_pin_sel), .o_mux_to_analog_ground(o_mux_to_analog_ground),
  .o_sample_switch(o_sample_switch), .o_dac_code(o_dac_code),
  .o_ext_power_ctrl_out(o_ext_power_ctrl_out), .o_int_n(o_int_n), .o_busy(o_busy),
  .o_alarm_flags(o_alarm_flags), .o_results(o_results));
